/* hw/gpp_pins.sv */
// Purpose: game-port and power-down pin control
// Assumes: config register values arrive as ports, inputs synchronous
// Notes: pins are inputs until the straps are latched
`timescale 1ns/10ps
`default_nettype none
module gpp_pins
  import gpp_pkg::*;
#(
  parameter int ADDR_W = 16
)(
  input  wire logic              CLOCK,
  input  wire logic              RESETN,
  input  wire logic              CLK_EN,
  input  wire logic [ADDR_W-1:0] IO_ADDR,
  input  wire logic              IO_RD_N,
  input  wire logic              IO_WR_N,
  input  wire logic [7:0]        THIRD_CONFIG_REGISTER,
  input  wire logic [7:0]        EXTENDED_CONFIG_REGISTER,
  input  wire logic [7:0]        FOURTH_CONFIG_REGISTER,
  input  wire logic [7:0]        SIXTH_CONFIG_REGISTER,
  input  wire logic [7:0]        INFRARED_CONFIG_REGISTER,
  input  wire logic [2:0]        PARALLEL_PORT_MODE,
  input  wire logic              GAME_READ_PIN_I,
  output logic                   GAME_READ_PIN_O,
  output logic                   GAME_READ_PIN_OE,
  input  wire logic              GAME_WRITE_PIN_I,
  output logic                   GAME_WRITE_PIN_O,
  output logic                   GAME_WRITE_PIN_OE,
  input  wire logic              POWER_DOWN_INPUT,
  output logic                   INFRARED_RECEIVE_TWO,
  output logic                   POWER_DOWN_ACTIVE,
  output logic                   CLOCK_SUPPLY_EN,
  output logic [7:0]             TRISTATE_FOURTH,
  output logic [7:0]             TRISTATE_SIXTH,
  output logic [7:0]             EXTENDED_FUNCTION_UNLOCK_REG,
  output logic                   PARALLEL_MODE_STRAP_LOW,
  output logic                   STRAPS_DONE
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  gpp_state_t state_r;
  gpp_state_t state_nxt;

  logic        strap_done;
  logic [7:0]  strap_unlock;
  logic        strap_mode;
  logic        rd_hit;
  logic        wr_hit;

  logic        game_mode_select_bit;
  logic        floppy_indicator_polarity;
  logic        extended_indicator_polarity;
  logic        power_down_polarity;
  logic        ir_rx2_select;
  logic        tri_game_pins;

  logic        pd_level_active;
  logic        pd_active;
  logic        floppy_ext_mode;
  logic        ext_port_mode;
  logic [3:0]  ext_mode_code;

  logic        game_read_strobe;
  logic        game_write_strobe;
  logic        floppy_extension_indicator;
  logic        extended_port_mode_indicator;
  logic        read_pin_nxt;
  logic        write_pin_nxt;
  logic        pins_drive;
  logic        oe_nxt;

  logic        read_pin_r;
  logic        write_pin_r;
  logic        read_oe_r;
  logic        write_oe_r;
  logic        ir_rx2_r;
  logic        pd_active_r;
  logic        clk_supply_r;
  logic [7:0]  tri_fourth_r;
  logic [7:0]  tri_sixth_r;
  logic [7:0]  tri_fourth_nxt;
  logic [7:0]  tri_sixth_nxt;
  logic [7:0]  unlock_r;
  logic        mode_strap_r;
  logic        done_r;

  ////////////////////////////////////////////////////////////////////////////
  // strap capture and host decode

  gpp_strap_latch u_strap (
    .clk          (CLOCK),
    .rst_n        (RESETN),
    .ce           (CLK_EN),
    .key_pin      (GAME_READ_PIN_I),
    .mode_pin     (GAME_WRITE_PIN_I),
    .done         (strap_done),
    .unlock_value (strap_unlock),
    .mode_bit     (strap_mode)
  );

  gpp_io_decode #(
    .ADDR_W (ADDR_W)
  ) u_decode (
    .addr   (IO_ADDR),
    .rd_n   (IO_RD_N),
    .wr_n   (IO_WR_N),
    .rd_hit (rd_hit),
    .wr_hit (wr_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configuration fields

  assign game_mode_select_bit        = THIRD_CONFIG_REGISTER[GPP_MODE_SEL_BIT]; // R01
  assign floppy_indicator_polarity   = EXTENDED_CONFIG_REGISTER[GPP_FDC_POL_BIT];
  assign extended_indicator_polarity = EXTENDED_CONFIG_REGISTER[GPP_EXT_POL_BIT];
  assign power_down_polarity         = EXTENDED_CONFIG_REGISTER[GPP_PD_POL_BIT];
  assign ext_mode_code               = EXTENDED_CONFIG_REGISTER[3:0];
  assign ir_rx2_select               = INFRARED_CONFIG_REGISTER[GPP_IR_RX2_SEL_BIT];
  assign tri_game_pins               = SIXTH_CONFIG_REGISTER[GPP_TRI_GAME_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // power-down input

  // polarity bit clear means active high
  assign pd_level_active = power_down_polarity ? ~POWER_DOWN_INPUT
                                               : POWER_DOWN_INPUT; // R09
  // infrared use takes the pin away from power control
  assign pd_active = pd_level_active && !ir_rx2_select; // R10

  assign tri_fourth_nxt = pd_active ? FOURTH_CONFIG_REGISTER : 8'h00; // R08
  assign tri_sixth_nxt  = pd_active ? SIXTH_CONFIG_REGISTER  : 8'h00; // R08

  ////////////////////////////////////////////////////////////////////////////
  // mode sequencing

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      GPP_ST_STRAP: begin
        if (strap_done) begin
          state_nxt = game_mode_select_bit ? GPP_ST_PORT : GPP_ST_ADAPTER; // R11
        end
      end
      GPP_ST_ADAPTER: begin
        if (game_mode_select_bit) begin
          state_nxt = GPP_ST_PORT; // R01
        end
      end
      GPP_ST_PORT: begin
        if (!game_mode_select_bit) begin
          state_nxt = GPP_ST_ADAPTER; // R01
        end
      end
      default: begin
        state_nxt = GPP_ST_STRAP;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin functions

  // strobes are active low toward the adapter
  assign game_read_strobe  = ~rd_hit; // R02
  assign game_write_strobe = ~wr_hit; // R03

  assign floppy_ext_mode = (PARALLEL_PORT_MODE == GPP_PRT_EXT_FDD) ||
                           (PARALLEL_PORT_MODE == GPP_PRT_EXT_2FDD); // R04
  assign ext_port_mode   = (ext_mode_code == GPP_PEXT_ADAPTER) ||
                           (ext_mode_code == GPP_PEXT_EPP)     ||
                           (ext_mode_code == GPP_PEXT_ECP)     ||
                           (ext_mode_code == GPP_PEXT_ECP_EPP); // R06

  assign floppy_extension_indicator   = gpp_drive_level(floppy_ext_mode,
                                                        floppy_indicator_polarity); // R04
  assign extended_port_mode_indicator = gpp_drive_level(ext_port_mode,
                                                        extended_indicator_polarity); // R06

  assign read_pin_nxt  = (state_nxt == GPP_ST_PORT) ? floppy_extension_indicator
                                                    : game_read_strobe;
  assign write_pin_nxt = (state_nxt == GPP_ST_PORT) ? extended_port_mode_indicator
                                                    : game_write_strobe;

  // pins stay inputs while straps are pending
  assign pins_drive = (state_nxt != GPP_ST_STRAP); // R11
  assign oe_nxt     = pins_drive && !(pd_active && tri_game_pins); // R08

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= GPP_ST_STRAP;
    end else if (CLK_EN) begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      read_pin_r  <= GPP_STROBE_IDLE;
      write_pin_r <= GPP_STROBE_IDLE;
      read_oe_r   <= 1'b0;
      write_oe_r  <= 1'b0;
    end else if (CLK_EN) begin
      read_pin_r  <= read_pin_nxt;
      write_pin_r <= write_pin_nxt;
      read_oe_r   <= oe_nxt;
      write_oe_r  <= oe_nxt;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      ir_rx2_r     <= 1'b0;
      pd_active_r  <= 1'b0;
      clk_supply_r <= 1'b1;
      tri_fourth_r <= 8'h00;
      tri_sixth_r  <= 8'h00;
    end else if (CLK_EN) begin
      ir_rx2_r     <= ir_rx2_select ? POWER_DOWN_INPUT : 1'b0; // R10
      pd_active_r  <= pd_active;
      clk_supply_r <= !pd_active; // R08
      tri_fourth_r <= tri_fourth_nxt;
      tri_sixth_r  <= tri_sixth_nxt;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      unlock_r     <= GPP_UNLOCK_RESET;
      mode_strap_r <= 1'b0;
      done_r       <= 1'b0;
    end else if (CLK_EN) begin
      unlock_r     <= strap_unlock; // R05
      mode_strap_r <= strap_mode; // R07
      done_r       <= strap_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign GAME_READ_PIN_O              = read_pin_r;
  assign GAME_READ_PIN_OE             = read_oe_r;
  assign GAME_WRITE_PIN_O             = write_pin_r;
  assign GAME_WRITE_PIN_OE            = write_oe_r;
  assign INFRARED_RECEIVE_TWO         = ir_rx2_r;
  assign POWER_DOWN_ACTIVE            = pd_active_r;
  assign CLOCK_SUPPLY_EN              = clk_supply_r;
  assign TRISTATE_FOURTH              = tri_fourth_r;
  assign TRISTATE_SIXTH               = tri_sixth_r;
  assign EXTENDED_FUNCTION_UNLOCK_REG = unlock_r;
  assign PARALLEL_MODE_STRAP_LOW      = mode_strap_r;
  assign STRAPS_DONE                  = done_r;

endmodule // gpp_pins
`default_nettype wire

/* shared/gpp_pkg.sv */
// Purpose: constants for the game-port and power-down pin block
// Assumes: config register contents arrive as plain ports
// Notes: polarity bits at zero mean the documented default level
//
// Notes on behaviour
// [R01] Bit 4 of the third config register picks adapter or portable mode, adapter after reset.
// [R02] In adapter mode a host read of I/O address 201h drives the game read strobe.
// [R03] In adapter mode a host write of I/O address 201h drives the game write strobe.
// [R04] In portable mode the floppy indicator shows Extension FDD/2FDD, polarity from bit 7.
// [R05] The unlock-key strap sampled at power-on reset picks unlock value 89h if high, 88h if low.
// [R06] In portable mode the extended indicator shows adapter/EPP/ECP/ECP-EPP, polarity bit 6.
// [R07] The parallel-mode strap on the game write pin is sampled at reset for the port mode.
// [R08] While power-down is active the clock supply is gated and masked pins are tristated.
// [R09] Power-down polarity comes from bit 4 of the extended register, active high by default.
// [R10] When the infrared register selects it, the power-down pin is infrared receive two.
// [R11] Straps latch at reset release, then pins turn to outputs and values hold until reset.
package gpp_pkg;

  localparam logic [15:0] GPP_GAME_IO_ADDR   = 16'h0201;
  localparam int          GPP_MODE_SEL_BIT   = 4;
  localparam int          GPP_FDC_POL_BIT    = 7;
  localparam int          GPP_EXT_POL_BIT    = 6;
  localparam int          GPP_PD_POL_BIT     = 4;
  localparam int          GPP_IR_RX2_SEL_BIT = 0;
  localparam int          GPP_TRI_GAME_BIT   = 0;
  localparam logic [7:0]  GPP_UNLOCK_HIGH    = 8'h89;
  localparam logic [7:0]  GPP_UNLOCK_LOW     = 8'h88;
  localparam logic [7:0]  GPP_UNLOCK_RESET   = 8'h89;
  localparam logic [3:0]  GPP_PEXT_ADAPTER   = 4'h1;
  localparam logic [3:0]  GPP_PEXT_EPP       = 4'h2;
  localparam logic [3:0]  GPP_PEXT_ECP       = 4'h3;
  localparam logic [3:0]  GPP_PEXT_ECP_EPP   = 4'h4;
  localparam logic [2:0]  GPP_PRT_EXT_FDD    = 3'h2;
  localparam logic [2:0]  GPP_PRT_EXT_2FDD   = 3'h3;
  localparam logic        GPP_STROBE_IDLE    = 1'b1;

  typedef enum logic [1:0] {
    GPP_ST_STRAP   = 2'b00,
    GPP_ST_ADAPTER = 2'b01,
    GPP_ST_PORT    = 2'b10
  } gpp_state_t;

  // level seen on a pin for an internal active flag; pol=0 gives the default
  function automatic logic gpp_drive_level(input logic active, input logic pol_high);
    gpp_drive_level = pol_high ? active : ~active;
  endfunction

endpackage

/* hw/gpp_strap_latch.sv */
// Purpose: capture the power-on straps once, at reset release
// Assumes: pins are undriven by the block until done goes high
// Notes: async reset loads constants only; capture is clocked
`timescale 1ns/10ps
`default_nettype none
module gpp_strap_latch
  import gpp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       key_pin,
  input  wire logic       mode_pin,
  output logic            done,
  output logic [7:0]      unlock_value,
  output logic            mode_bit
);

  logic [7:0] unlock_nxt;

  assign unlock_nxt = key_pin ? GPP_UNLOCK_HIGH : GPP_UNLOCK_LOW; // R05

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done         <= 1'b0;
      unlock_value <= GPP_UNLOCK_RESET;
      mode_bit     <= 1'b0;
    end else if (ce && !done) begin
      done         <= 1'b1; // R11
      unlock_value <= unlock_nxt; // R05
      mode_bit     <= mode_pin; // R07
    end
  end

endmodule // gpp_strap_latch
`default_nettype wire

/* hw/gpp_io_decode.sv */
// Purpose: decode host accesses to the game I/O port
// Assumes: host strobes are active low and synchronous
// Notes: outputs are combinational; the top registers them
`timescale 1ns/10ps
`default_nettype none
module gpp_io_decode
  import gpp_pkg::*;
#(
  parameter int ADDR_W = 16
)(
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              rd_n,
  input  wire logic              wr_n,
  output logic                   rd_hit,
  output logic                   wr_hit
);

  logic addr_hit;

  assign addr_hit = (addr == GPP_GAME_IO_ADDR[ADDR_W-1:0]);
  assign rd_hit   = addr_hit && !rd_n; // R02
  assign wr_hit   = addr_hit && !wr_n; // R03

endmodule // gpp_io_decode
`default_nettype wire

/* tb/gpp_far_pin.sv */
// Purpose: far-side model of one strap pin and its resistor
// Assumes: pull is the level the board resistor gives
// Notes: the released pin shows the resistor, never the last drive
`timescale 1ns/10ps
`default_nettype none
module gpp_far_pin (
  input  wire logic drv,
  input  wire logic oe,
  input  wire logic pull,
  output logic      pin
);
  assign pin = oe ? drv : pull;
endmodule // gpp_far_pin
`default_nettype wire

/* tb/gpp_pins_asserts.sv */
// Purpose: port assertions for gpp_pins
// Assumes: CLK_EN high while straps latch
// Notes: bound to every gpp_pins instance
`timescale 1ns/10ps
`default_nettype none
module gpp_pins_asserts
  import gpp_pkg::*;
#(
  parameter int ADDR_W = 16
)(
  input wire logic              CLOCK,
  input wire logic              RESETN,
  input wire logic              CLK_EN,
  input wire logic [ADDR_W-1:0] IO_ADDR,
  input wire logic              IO_RD_N,
  input wire logic              IO_WR_N,
  input wire logic [7:0]        THIRD_CONFIG_REGISTER,
  input wire logic [7:0]        EXTENDED_CONFIG_REGISTER,
  input wire logic [7:0]        FOURTH_CONFIG_REGISTER,
  input wire logic [7:0]        INFRARED_CONFIG_REGISTER,
  input wire logic [2:0]        PARALLEL_PORT_MODE,
  input wire logic              GAME_READ_PIN_I,
  input wire logic              GAME_READ_PIN_O,
  input wire logic              GAME_WRITE_PIN_I,
  input wire logic              GAME_WRITE_PIN_O,
  input wire logic              POWER_DOWN_INPUT,
  input wire logic              INFRARED_RECEIVE_TWO,
  input wire logic              POWER_DOWN_ACTIVE,
  input wire logic              CLOCK_SUPPLY_EN,
  input wire logic [7:0]        TRISTATE_FOURTH,
  input wire logic [7:0]        EXTENDED_FUNCTION_UNLOCK_REG,
  input wire logic              PARALLEL_MODE_STRAP_LOW,
  input wire logic              STRAPS_DONE
);
  wire [7:0] ec = EXTENDED_CONFIG_REGISTER;
  wire pd_on = CLK_EN && (POWER_DOWN_INPUT ^ ec[GPP_PD_POL_BIT]) && !INFRARED_CONFIG_REGISTER[0];
  wire run = CLK_EN && STRAPS_DONE && !pd_on;
  wire ad = run && !THIRD_CONFIG_REGISTER[GPP_MODE_SEL_BIT];
  wire pt = run && THIRD_CONFIG_REGISTER[GPP_MODE_SEL_BIT];
  wire hit = ad && IO_ADDR == GPP_GAME_IO_ADDR;
  wire fdd = PARALLEL_PORT_MODE == GPP_PRT_EXT_FDD || PARALLEL_PORT_MODE == GPP_PRT_EXT_2FDD;
  wire xm = ec[3:0] >= GPP_PEXT_ADAPTER && ec[3:0] <= GPP_PEXT_ECP_EPP;
  wire fdd_lvl = fdd ~^ ec[GPP_FDC_POL_BIT];
  wire xm_lvl = xm ~^ ec[GPP_EXT_POL_BIT];
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  chk_read_strobe: assert property (hit && !IO_RD_N |=> !GAME_READ_PIN_O)
    else $error("read strobe missing");
  chk_write_strobe: assert property (hit && !IO_WR_N |=> !GAME_WRITE_PIN_O)
    else $error("write strobe missing");
  chk_strobe_idle: assert property (ad && IO_RD_N && IO_WR_N |=> GAME_READ_PIN_O && GAME_WRITE_PIN_O)
    else $error("strobe not idle");
  chk_floppy_ind: assert property (pt |=> GAME_READ_PIN_O == $past(fdd_lvl))
    else $error("floppy indicator wrong");
  chk_ext_ind: assert property (pt |=> GAME_WRITE_PIN_O == $past(xm_lvl))
    else $error("extended indicator wrong");
  chk_strap_latch: assert property ($rose(STRAPS_DONE) |-> PARALLEL_MODE_STRAP_LOW == $past(GAME_WRITE_PIN_I)
    && EXTENDED_FUNCTION_UNLOCK_REG == ($past(GAME_READ_PIN_I) ? GPP_UNLOCK_HIGH : GPP_UNLOCK_LOW))
    else $error("strap value wrong");
  chk_strap_hold: assert property (STRAPS_DONE && $past(STRAPS_DONE) |->
    $stable(EXTENDED_FUNCTION_UNLOCK_REG) && $stable(PARALLEL_MODE_STRAP_LOW))
    else $error("strap value moved");
  chk_pd_enter: assert property (pd_on |=> POWER_DOWN_ACTIVE && !CLOCK_SUPPLY_EN
    && TRISTATE_FOURTH == $past(FOURTH_CONFIG_REGISTER))
    else $error("power-down not entered");
  chk_pd_clear: assert property (CLK_EN && !pd_on |=> !POWER_DOWN_ACTIVE && CLOCK_SUPPLY_EN
    && TRISTATE_FOURTH == 8'h00)
    else $error("power-down not left");
  chk_ir_route: assert property (CLK_EN && INFRARED_CONFIG_REGISTER[0] |=>
    INFRARED_RECEIVE_TWO == $past(POWER_DOWN_INPUT))
    else $error("infrared route wrong");
  chk_freeze_hold: assert property (!CLK_EN |=> $stable(GAME_READ_PIN_O) && $stable(POWER_DOWN_ACTIVE)
    && $stable(STRAPS_DONE) && $stable(EXTENDED_FUNCTION_UNLOCK_REG))
    else $error("state moved while frozen");
  cov_read: cover property (hit && !IO_RD_N);
  cov_port: cover property (pt && fdd);
  cov_pd: cover property (pd_on);
endmodule // gpp_pins_asserts
bind gpp_pins gpp_pins_asserts #(.ADDR_W(ADDR_W)) u_chk (.CLOCK(CLOCK), .RESETN(RESETN),
  .CLK_EN(CLK_EN), .IO_ADDR(IO_ADDR), .IO_RD_N(IO_RD_N), .IO_WR_N(IO_WR_N),
  .THIRD_CONFIG_REGISTER(THIRD_CONFIG_REGISTER), .EXTENDED_CONFIG_REGISTER(EXTENDED_CONFIG_REGISTER),
  .FOURTH_CONFIG_REGISTER(FOURTH_CONFIG_REGISTER),
  .INFRARED_CONFIG_REGISTER(INFRARED_CONFIG_REGISTER), .PARALLEL_PORT_MODE(PARALLEL_PORT_MODE),
  .GAME_READ_PIN_I(GAME_READ_PIN_I), .GAME_READ_PIN_O(GAME_READ_PIN_O),
  .GAME_WRITE_PIN_I(GAME_WRITE_PIN_I), .GAME_WRITE_PIN_O(GAME_WRITE_PIN_O),
  .POWER_DOWN_INPUT(POWER_DOWN_INPUT), .INFRARED_RECEIVE_TWO(INFRARED_RECEIVE_TWO),
  .POWER_DOWN_ACTIVE(POWER_DOWN_ACTIVE), .CLOCK_SUPPLY_EN(CLOCK_SUPPLY_EN),
  .TRISTATE_FOURTH(TRISTATE_FOURTH), .EXTENDED_FUNCTION_UNLOCK_REG(EXTENDED_FUNCTION_UNLOCK_REG),
  .PARALLEL_MODE_STRAP_LOW(PARALLEL_MODE_STRAP_LOW), .STRAPS_DONE(STRAPS_DONE));
`default_nettype wire

/* tb/gpp_pins_tb.sv */
// Purpose: self-checking bench for gpp_pins
// Assumes: inputs change at the falling edge
// Notes: row layout is mode, ext, par mode, addr, rd/wr, rd/wr pin
`timescale 1ns/10ps
`default_nettype none
module gpp_pins_tb;
  import gpp_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, rd_n = 1'b1, wr_n = 1'b1, pd_in = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  third = 8'h00, ext = 8'h00, fourth = 8'h00, sixth = 8'h00, ir = 8'h00;
  logic [2:0]  pmode = 3'h0;
  logic        ce = 1'b1;
  logic        key_lvl = 1'b1, mode_lvl = 1'b0;
  logic        rd_i, rd_o, rd_oe, wr_i, wr_o, wr_oe, ir2, pd_act, csup, done, strap;
  logic [7:0]  tri4, tri6, unlock;
  int          fails = 0, check_count = 0;
  logic [39:0] rows [12] = '{40'h00_0002_0111, 40'h00_0002_0122, 40'h00_0002_0013,
    40'h00_0012_0113, 40'h10_0202_0111, 40'h18_1300_0032, 40'h14_2000_0033,
    40'h10_3100_0032, 40'h10_4000_0032, 40'h14_5200_0030, 40'h1C_0300_0032,
    40'h00_0000_0033};
  always #2.5 clk = ~clk;
  gpp_far_pin u_key (.drv(rd_o), .oe(rd_oe), .pull(key_lvl), .pin(rd_i));
  gpp_far_pin u_mode (.drv(wr_o), .oe(wr_oe), .pull(mode_lvl), .pin(wr_i));
  gpp_pins DUT (.CLOCK(clk), .RESETN(rstn), .CLK_EN(ce), .IO_ADDR(addr), .IO_RD_N(rd_n),
    .IO_WR_N(wr_n), .THIRD_CONFIG_REGISTER(third), .EXTENDED_CONFIG_REGISTER(ext),
    .FOURTH_CONFIG_REGISTER(fourth), .SIXTH_CONFIG_REGISTER(sixth),
    .INFRARED_CONFIG_REGISTER(ir), .PARALLEL_PORT_MODE(pmode), .GAME_READ_PIN_I(rd_i),
    .GAME_READ_PIN_O(rd_o), .GAME_READ_PIN_OE(rd_oe), .GAME_WRITE_PIN_I(wr_i),
    .GAME_WRITE_PIN_O(wr_o), .GAME_WRITE_PIN_OE(wr_oe), .POWER_DOWN_INPUT(pd_in),
    .INFRARED_RECEIVE_TWO(ir2), .POWER_DOWN_ACTIVE(pd_act), .CLOCK_SUPPLY_EN(csup),
    .TRISTATE_FOURTH(tri4), .TRISTATE_SIXTH(tri6), .EXTENDED_FUNCTION_UNLOCK_REG(unlock),
    .PARALLEL_MODE_STRAP_LOW(strap), .STRAPS_DONE(done));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic edge_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000;
    fails++;
    stop_test();
  end
  initial begin
    edge_n(2);
    chk("reset pins", 16'({rd_o, rd_oe, wr_o, wr_oe, done, csup, pd_act, ir2}), 16'h00A4);
    chk("reset unlock", 16'(unlock), 16'(GPP_UNLOCK_RESET));
    rstn = 1'b1;
    edge_n(2);
    chk("strap high", {unlock, 3'h0, strap, 2'h0, rd_oe, wr_oe}, 16'h8903);
    key_lvl = 1'b0;
    mode_lvl = 1'b1;
    edge_n(2);
    chk("strap hold", {unlock, 7'h00, strap}, 16'h8900);
    rstn = 1'b0;
    edge_n(1);
    chk("reset again", 16'({rd_oe, wr_oe, done}), 16'h0000);
    rstn = 1'b1;
    edge_n(2);
    chk("strap low", {unlock, 7'h00, strap}, 16'h8801);
    for (int i = 0; i < 12; i++) begin
      third = {3'h0, rows[i][36], 4'h0};
      ext = rows[i][35:28];
      pmode = rows[i][26:24];
      addr = rows[i][23:8];
      rd_n = rows[i][5];
      wr_n = rows[i][4];
      edge_n(1);
      chk("row pins", 16'({rd_o, wr_o}), 16'(rows[i][1:0]));
    end
    fourth = 8'hA5;
    sixth = 8'h01;
    pd_in = 1'b1;
    edge_n(1);
    chk("pd on", 16'({pd_act, csup, rd_oe, wr_oe}), 16'h0008);
    chk("pd masks", {tri4, tri6}, 16'hA501);
    pd_in = 1'b0;
    edge_n(1);
    chk("pd off", 16'({pd_act, csup, rd_oe, wr_oe, tri4}), 16'h0700);
    ext = 8'h10;
    edge_n(1);
    chk("pd low level", 16'({pd_act, csup}), 16'h0002);
    ir = 8'h01;
    pd_in = 1'b1;
    edge_n(1);
    chk("ir high", 16'({pd_act, csup, ir2}), 16'h0003);
    pd_in = 1'b0;
    edge_n(1);
    chk("ir low", 16'({pd_act, csup, ir2}), 16'h0002);
    // clock enable low: a strobe and a power-down request must wait
    ce = 1'b0;
    ir = 8'h00;
    addr = 16'h0201;
    rd_n = 1'b0;
    edge_n(1);
    chk("frozen", 16'({rd_o, pd_act, csup, ir2}), 16'h000A);
    ce = 1'b1;
    edge_n(1);
    chk("unfrozen", 16'({rd_o, pd_act, csup, ir2}), 16'h0004);
    stop_test();
  end
endmodule // gpp_pins_tb
`default_nettype wire
